// file: rtl/scl_defines.svh
// constants of the serial command line front end
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH
// character codes
`define CH_BS 8'h08
`define CH_LF 8'h0A
`define CH_CR 8'h0D
`define CH_XON 8'h11
`define CH_XOFF 8'h13
`define CH_NAK 8'h15
`define CH_CAN 8'h18
`define CH_ESC 8'h1B
`define CH_SP 8'h20
`define CH_BANG 8'h21
`define CH_PROMPT 8'h3E
`define CH_CTRL_TOP 8'h1F
// framing: one start, eight data, one stop
`define RX_LAST_BIT 3'h7
`define TX_FRAME_BITS 4'hA
// timing
`define BAUD_DIV_DEF 16'h0364
`define CLK_HZ 100000000
`define XON_PERIOD_S 5
`define XON_PERIOD_CYC (`XON_PERIOD_S * `CLK_HZ)
// buffers
`define BUF_DEPTH 256
`define BUF_FULL 9'h100
`define CMDQ_DEPTH 4
`define TXQ_DEPTH 16
`endif

// file: rtl/scl_pkg.sv
// types of the serial command line front end
package scl_pkg;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} rx_st_e;
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} cmd_word_s;
	typedef struct packed {
		rx_st_e rx_st;
		logic [2:0] sync;
		logic rx_lvl;
		logic [15:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic [15:0] tx_cnt;
		logic txd;
		logic tx_halt;
		logic [7:0] wr;
		logic [7:0] rd;
		logic [8:0] cnt;
		logic [8:0] lines;
		logic line_out;
		logic ovf;
		logic last_term;
		logic [7:0] last_tc;
		logic [23:0] seq;
		logic [1:0] seq_n;
		logic done_pend;
		logic nak_pend;
		logic bang_pend;
		logic [31:0] xon_tmr;
		logic dsr;
		logic remote;
		logic qerr;
		logic resp_ready;
	} core_s;
endpackage

// file: rtl/serial_command_line.sv
// serial command line front end with its queue module
// Function
// RL1 - link is 8N1, flow on, prompt off
// RL2 - escape empties input, sends CR LF
// RL3 - backspace drops last non-terminator character
// RL4 - CR or LF ends line, starts parsing
// RL5 - after parsing send CR LF
// RL6 - ready low after reset, high when ready
// RL7 - terminator drops ready, sends XOFF if flow; code sends no XOFF while the buffer is in overflow
// RL8 - flow off: never send or obey XON/XOFF
// RL9 - 256-byte buffer, overflow drops oldest, holds ready
// RL10 - queued lines processed back to back
// RL11 - idle with flow: XON every five seconds
// RL12 - other control codes are ignored
// RL13 - flow on: XON enables, XOFF halts transmitter
// RL14 - cancel empties receive and transmit queues
// RL15 - XOFF halt posts error; XON sends output, bang
// RL16 - echo printable, BS as BS SP BS, one terminator
// RL17 - terminator answered XOFF CR or XOFF; code sends no XOFF while the buffer is in overflow
// RL18 - host sends only between XON and XOFF
// RL19 - lost echo sends NAK and posts error
// RL20 - prompt mode sends CR LF prompt character
// RL21 - host verifies echo, retries with escape
// RL22 - each command sets remote mode
// RL23 - start low, data LSB first, stop high
`timescale 1ns/1ns
`include "scl_defines.svh"

// ****************************************
// queue with valid and ready on both sides
// ****************************************
module scl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk_i, // clock
	input wire logic rst_n_i, // async reset
	input wire logic flush_i, // empty the queue
	input wire logic in_valid_i, // write request
	output logic in_ready_o, // room left
	input wire logic [WIDTH-1:0] in_data_i, // write data
	output logic out_valid_o, // data present
	input wire logic out_ready_i, // drain
	output logic [WIDTH-1:0] out_data_o, // head word
	output logic afull_o // at most one slot left
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;
	fifo_s st;
	fifo_s next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic wr_en;
	logic rd_en;

	// handshake and flags
	assign in_ready_o = st.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = st.cnt != '0;
	assign out_data_o = mem[st.rp];
	assign afull_o = st.cnt >= (AW+1)'(DEPTH - 1);
	assign wr_en = in_valid_i && in_ready_o && !flush_i;
	assign rd_en = out_valid_o && out_ready_i && !flush_i;

	// pointer update
	always_comb begin
		next_st = st;
		if (flush_i) begin
			next_st = '0;
		end else begin
			if (wr_en) begin
				next_st.wp = st.wp + 1'b1;
			end
			if (rd_en) begin
				next_st.rp = st.rp + 1'b1;
			end
			next_st.cnt = st.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// storage
	always_ff @(posedge ref_clk_i) begin
		if (wr_en) begin
			mem[st.wp] <= in_data_i;
		end
	end
endmodule

// ****************************************
// command line front end
// ****************************************
module serial_command_line import scl_pkg::*; #(
	parameter logic [15:0] BAUD_DIV = `BAUD_DIV_DEF,
	parameter logic [31:0] XON_CYCLES = 32'(`XON_PERIOD_CYC),
	parameter int TXQ_DEPTH = `TXQ_DEPTH
) (
	input wire logic ref_clk_i, // 100 MHz clock
	input wire logic rst_n_i, // async reset
	input wire logic rxd_i, // serial in pin
	output logic txd_o, // serial out pin
	output logic dsr_o, // ready to receive
	input wire logic ready_i, // device can take commands
	input wire logic flow_en_i, // XON/XOFF enable
	input wire logic echo_en_i, // echo mode
	input wire logic prompt_en_i, // prompt mode
	output cmd_word_s cmd_o, // line character to parser
	output logic cmd_valid_o, // cmd_o valid
	input wire logic cmd_ready_i, // parser takes cmd_o
	input wire logic parse_done_i, // line dispatched
	input wire logic [7:0] resp_data_i, // response byte
	input wire logic resp_valid_i, // response valid
	output logic resp_ready_o, // response taken
	output logic remote_o, // remote mode
	input wire logic go_local_i, // leave remote mode
	output logic query_err_o // query error pulse
);
	localparam core_s CORE_RST = '{rx_st: RX_IDLE, sync: 3'h7, rx_lvl: 1'b1, txd: 1'b1, default: '0};
	core_s st;
	core_s next_st;
	logic [7:0] mem [`BUF_DEPTH];
	logic [7:0] rx_c;
	logic [7:0] buf_last;
	logic [7:0] buf_head;
	logic rx_done;
	logic ev_term;
	logic ev_esc;
	logic ev_can;
	logic ev_bs;
	logic ev_put;
	logic ev_full;
	logic ev_xon;
	logic ev_xoff;
	logic mem_we;
	logic rd_go;
	logic tx_pop;
	logic seq_push;
	logic seq_free;
	logic resp_take;
	logic idle_line;
	logic cmd_in_ready;
	logic txq_valid;
	logic txq_ready;
	logic txq_afull;
	logic [7:0] txq_data;
	logic [1:0] want_n;
	logic [23:0] want_seq;

	function automatic logic is_term(input logic [7:0] ch);
		return (ch == `CH_CR) || (ch == `CH_LF);
	endfunction

	// received character decode
	assign rx_c = st.rx_sh;
	assign buf_last = mem[st.wr - 8'h01];
	assign buf_head = mem[st.rd];
	assign ev_term = rx_done && is_term(rx_c) && !(st.last_term && rx_c != st.last_tc); // [RL4] [RL16]
	assign ev_esc = rx_done && rx_c == `CH_ESC;
	assign ev_can = rx_done && rx_c == `CH_CAN;
	assign ev_xon = rx_done && flow_en_i && rx_c == `CH_XON; // [RL8]
	assign ev_xoff = rx_done && flow_en_i && rx_c == `CH_XOFF; // [RL8]
	assign ev_bs = rx_done && rx_c == `CH_BS && st.cnt != '0 && !is_term(buf_last); // [RL3]
	assign ev_put = rx_done && rx_c > `CH_CTRL_TOP; // [RL12]
	// a terminator arriving on a full buffer overwrites the oldest too
	assign ev_full = (ev_put || ev_term) && st.cnt == `BUF_FULL; // [RL9]
	assign mem_we = ev_put || ev_term;
	assign idle_line = ready_i && st.lines == '0 && !st.line_out && !st.ovf;

	// line reader feeds one line at a time to the parser
	assign rd_go = st.lines != '0 && !st.line_out && st.cnt != '0 && cmd_in_ready && !ev_full && !ev_esc && !ev_can; // [RL10]

	// transmit side handshakes
	assign seq_free = st.seq_n == 2'h0;
	assign resp_take = resp_valid_i && st.resp_ready;
	assign seq_push = !seq_free && txq_ready && !resp_take && !ev_can;
	assign tx_pop = st.tx_bit == 4'h0 && txq_valid && !(st.tx_halt && flow_en_i); // [RL13]

	// bytes that a received character asks to send
	always_comb begin
		want_n = 2'h0;
		want_seq = 24'h000000;
		if (ev_term) begin
			if (flow_en_i && !st.ovf) begin
				want_n = echo_en_i ? 2'h2 : 2'h1; // [RL7] [RL17]
				want_seq = {`CH_XOFF, `CH_CR, 8'h00};
			end else if (echo_en_i) begin
				want_n = 2'h1;
				want_seq = {rx_c, 16'h0000};
			end
		end else if (ev_esc) begin
			want_n = 2'h2; // [RL2]
			want_seq = {`CH_CR, `CH_LF, 8'h00};
		end else if (ev_bs && echo_en_i) begin
			want_n = 2'h3; // [RL16]
			want_seq = {`CH_BS, `CH_SP, `CH_BS};
		end else if (ev_put && echo_en_i) begin
			want_n = 2'h1; // [RL16]
			want_seq = {rx_c, 16'h0000};
		end
	end

	// next state
	always_comb begin
		next_st = st;
		rx_done = 1'b0;
		// pin synchroniser, level taken when last two agree
		next_st.sync = {st.sync[1:0], rxd_i};
		if (st.sync[1] == st.sync[2]) begin
			next_st.rx_lvl = st.sync[2];
		end
		// receiver, sampling mid bit
		next_st.rx_cnt = st.rx_cnt - 16'h0001;
		unique case (st.rx_st)
			RX_IDLE: begin
				next_st.rx_cnt = BAUD_DIV >> 1;
				if (!st.rx_lvl) begin
					next_st.rx_st = RX_START;
				end
			end
			RX_START: begin
				if (st.rx_cnt == '0) begin
					next_st.rx_cnt = BAUD_DIV - 16'h0001;
					next_st.rx_bit = 3'h0;
					next_st.rx_st = st.rx_lvl ? RX_IDLE : RX_DATA; // [RL23]
				end
			end
			RX_DATA: begin
				if (st.rx_cnt == '0) begin
					next_st.rx_sh = {st.rx_lvl, st.rx_sh[7:1]}; // [RL23]
					next_st.rx_cnt = BAUD_DIV - 16'h0001;
					next_st.rx_bit = st.rx_bit + 3'h1;
					if (st.rx_bit == `RX_LAST_BIT) begin
						next_st.rx_st = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (st.rx_cnt == '0) begin
					rx_done = st.rx_lvl; // [RL1] [RL23]
					next_st.rx_st = RX_IDLE;
				end
			end
			default: begin
				next_st.rx_st = RX_IDLE;
			end
		endcase
		// transmitter
		if (tx_pop) begin
			next_st.tx_sh = {1'b1, txq_data, 1'b0}; // [RL23]
			next_st.tx_bit = `TX_FRAME_BITS;
			next_st.tx_cnt = BAUD_DIV - 16'h0001;
			next_st.txd = 1'b0;
		end else if (st.tx_bit != 4'h0) begin
			next_st.tx_cnt = st.tx_cnt - 16'h0001;
			if (st.tx_cnt == '0) begin
				next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
				next_st.txd = st.tx_sh[1];
				next_st.tx_bit = st.tx_bit - 4'h1;
				next_st.tx_cnt = BAUD_DIV - 16'h0001;
			end
		end
		// input buffer
		if (rx_done) begin
			next_st.last_term = ev_term;
			next_st.last_tc = rx_c;
		end
		if (st.cnt == '0 && st.lines == '0 && !st.line_out) begin
			next_st.ovf = 1'b0;
		end
		if (ev_can || ev_esc) begin
			next_st.wr = 8'h00; // [RL2] [RL14]
			next_st.rd = 8'h00;
			next_st.cnt = 9'h000;
			next_st.lines = 9'h000;
			next_st.line_out = 1'b0;
			next_st.ovf = 1'b0;
		end else begin
			if (mem_we) begin
				next_st.wr = st.wr + 8'h01;
				if (ev_full) begin
					next_st.rd = st.rd + 8'h01; // [RL9]
					next_st.ovf = 1'b1;
					if (is_term(buf_head)) begin
						next_st.lines = next_st.lines - 9'h001;
					end
				end else begin
					next_st.cnt = next_st.cnt + 9'h001;
				end
			end
			if (ev_term) begin
				next_st.lines = next_st.lines + 9'h001; // [RL4]
			end
			if (ev_bs) begin
				next_st.wr = st.wr - 8'h01; // [RL3]
				next_st.cnt = next_st.cnt - 9'h001;
			end
			if (rd_go) begin
				next_st.rd = st.rd + 8'h01;
				next_st.cnt = next_st.cnt - 9'h001;
				if (is_term(buf_head)) begin
					next_st.lines = next_st.lines - 9'h001;
					next_st.line_out = 1'b1;
				end
			end
			if (parse_done_i && st.line_out) begin
				next_st.line_out = 1'b0; // [RL10]
				next_st.done_pend = 1'b1;
			end
		end
		// flow control of the transmitter
		next_st.qerr = 1'b0;
		if (ev_xoff) begin
			next_st.tx_halt = 1'b1; // [RL13]
			next_st.qerr = 1'b1; // [RL15]
		end
		if (ev_xon) begin
			next_st.tx_halt = 1'b0; // [RL13]
			if (st.tx_halt) begin
				next_st.bang_pend = 1'b1; // [RL15]
			end
		end
		if (!(flow_en_i && idle_line)) begin
			next_st.xon_tmr = 32'h00000000;
		end else if (st.xon_tmr != '0) begin
			next_st.xon_tmr = st.xon_tmr - 32'h00000001;
		end
		// output sequencer, one byte per cycle into the queue
		if (seq_push) begin
			next_st.seq = {st.seq[15:0], 8'h00};
			next_st.seq_n = st.seq_n - 2'h1;
		end
		if (ev_can) begin
			next_st.seq_n = 2'h0; // [RL14]
			next_st.done_pend = 1'b0;
			next_st.nak_pend = 1'b0;
			next_st.bang_pend = 1'b0;
		end else if (want_n != 2'h0) begin
			if (seq_free) begin
				next_st.seq = want_seq;
				next_st.seq_n = want_n;
			end else if (echo_en_i) begin
				next_st.nak_pend = 1'b1; // [RL19]
				next_st.qerr = 1'b1;
			end
		end else if (seq_free) begin
			if (st.done_pend) begin
				next_st.done_pend = 1'b0;
				next_st.seq = {`CH_CR, `CH_LF, `CH_PROMPT}; // [RL5] [RL20]
				next_st.seq_n = prompt_en_i ? 2'h3 : 2'h2;
			end else if (st.nak_pend) begin
				next_st.nak_pend = 1'b0;
				next_st.seq = {`CH_NAK, 16'h0000}; // [RL19]
				next_st.seq_n = 2'h1;
			end else if (st.bang_pend) begin
				if (!txq_valid && st.tx_bit == 4'h0) begin
					next_st.bang_pend = 1'b0;
					next_st.seq = {`CH_BANG, 16'h0000}; // [RL15]
					next_st.seq_n = 2'h1;
				end
			end else if (flow_en_i && idle_line && st.xon_tmr == '0) begin
				next_st.seq = {`CH_XON, 16'h0000}; // [RL11]
				next_st.seq_n = 2'h1;
				next_st.xon_tmr = XON_CYCLES - 32'h00000001;
			end
		end
		// registered outputs
		next_st.dsr = idle_line && !ev_term && !ev_full; // [RL6] [RL7] [RL9]
		if (go_local_i) begin
			next_st.remote = 1'b0;
		end
		if (ev_term) begin
			next_st.remote = 1'b1; // [RL22]
		end
		next_st.resp_ready = !txq_afull;
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= CORE_RST;
		end else begin
			st <= next_st;
		end
	end

	// line storage, overwrites the oldest when full
	always_ff @(posedge ref_clk_i) begin
		if (mem_we && !ev_esc && !ev_can) begin
			mem[st.wr] <= rx_c;
		end
	end

	// queue toward the parser
	scl_fifo #(.WIDTH(9), .DEPTH(`CMDQ_DEPTH)) u_cmdq (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(ev_esc || ev_can),
		.in_valid_i(rd_go),
		.in_ready_o(cmd_in_ready),
		.in_data_i({is_term(buf_head), buf_head}),
		.out_valid_o(cmd_valid_o),
		.out_ready_i(cmd_ready_i),
		.out_data_o(cmd_o),
		.afull_o()
	);

	// transmit queue
	scl_fifo #(.WIDTH(8), .DEPTH(TXQ_DEPTH)) u_txq (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(ev_can),
		.in_valid_i(resp_take || seq_push),
		.in_ready_o(txq_ready),
		.in_data_i(resp_take ? resp_data_i : st.seq[23:16]),
		.out_valid_o(txq_valid),
		.out_ready_i(tx_pop),
		.out_data_o(txq_data),
		.afull_o(txq_afull)
	);

	// outputs
	assign txd_o = st.txd;
	assign dsr_o = st.dsr;
	assign remote_o = st.remote;
	assign query_err_o = st.qerr;
	assign resp_ready_o = st.resp_ready;

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_ready_low;
		!ready_i |=> !dsr_o;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready high while device not ready"); // [RL6]

	property p_term_dsr;
		ev_term |=> !dsr_o [*2];
	endproperty
	a_term_dsr: assert property (p_term_dsr) else $error("ready not low after terminator"); // [RL7]

	property p_term_xoff;
		ev_term && flow_en_i && !st.ovf && seq_free |=> st.seq[23:16] == `CH_XOFF && st.seq_n == (echo_en_i ? 2'h2 : 2'h1);
	endproperty
	a_term_xoff: assert property (p_term_xoff) else $error("terminator not answered by XOFF"); // [RL17]

	property p_noflow;
		seq_push && !flow_en_i && $stable(flow_en_i) |-> st.seq[23:16] != `CH_XON && st.seq[23:16] != `CH_XOFF;
	endproperty
	a_noflow: assert property (p_noflow) else $error("flow character sent with flow off"); // [RL8]

	property p_esc;
		ev_esc && seq_free |=> st.cnt == '0 && st.seq[23:8] == {`CH_CR, `CH_LF} && st.seq_n == 2'h2;
	endproperty
	a_esc: assert property (p_esc) else $error("escape did not clear and answer"); // [RL2]

	property p_bs;
		ev_bs && !rd_go |=> st.cnt == $past(st.cnt) - 9'h001 && st.wr == $past(st.wr) - 8'h01;
	endproperty
	a_bs: assert property (p_bs) else $error("backspace did not remove a character"); // [RL3]

	property p_full;
		ev_full |=> st.ovf && st.cnt == `BUF_FULL && !dsr_o;
	endproperty
	a_full: assert property (p_full) else $error("overflow not flagged"); // [RL9]

	property p_halt;
		ev_xoff |=> st.tx_halt && !tx_pop && query_err_o;
	endproperty
	a_halt: assert property (p_halt) else $error("XOFF did not halt transmitter"); // [RL13]

	property p_can;
		ev_can |=> st.cnt == '0 && st.seq_n == 2'h0 && !txq_valid;
	endproperty
	a_can: assert property (p_can) else $error("cancel left queued data"); // [RL14]

	property p_xon_rep;
		seq_free && flow_en_i && idle_line && st.xon_tmr == '0 && !rx_done && !st.done_pend && !st.nak_pend && !st.bang_pend
			|=> st.seq[23:16] == `CH_XON && st.xon_tmr == XON_CYCLES - 32'h00000001;
	endproperty
	a_xon_rep: assert property (p_xon_rep) else $error("XON not repeated"); // [RL11]

	property p_echo_bs;
		ev_bs && echo_en_i && seq_free |=> st.seq == {`CH_BS, `CH_SP, `CH_BS} && st.seq_n == 2'h3;
	endproperty
	a_echo_bs: assert property (p_echo_bs) else $error("backspace echo wrong"); // [RL16]

	property p_remote;
		ev_term |=> remote_o;
	endproperty
	a_remote: assert property (p_remote) else $error("command did not set remote"); // [RL22]

	property p_frame;
		tx_pop |=> !txd_o;
	endproperty
	a_frame: assert property (p_frame) else $error("frame without start bit"); // [RL23]

	c_term: cover property (ev_term ##[1:20] cmd_valid_o);
	c_full: cover property (ev_full);
	c_halt: cover property (ev_xoff ##[1:1000] ev_xon);
	c_done: cover property (parse_done_i && st.line_out);
endmodule

// file: tb/host_term.sv
// host terminal model on the far side of the serial link
`timescale 1ns/1ns
module host_term #(
	parameter int DIV = 16
) (
	input wire logic clk_i, // bench clock
	input wire logic line_i, // device serial out
	output logic line_o // host serial out, idles high
);
	// ****************************************
	// state
	// ****************************************
	logic [7:0] got[$]; // bytes heard from the device
	logic stopped = 1'b0; // device asked us to hold off
	logic obey = 1'b1; // cleared when a scenario floods on purpose
	logic [7:0] sh;
	int xoffs = 0;
	int stalls = 0; // waits for XON that ran out
	initial line_o = 1'b1;
	// ****************************************
	// sender
	// ****************************************
	// one frame: low start, data LSB first, high stop
	task automatic put(input logic [7:0] b);
		// hold off after XOFF until XON arrives
		for (int w = 0; w < 20000 && obey && stopped; w++) @(posedge clk_i);
		if (obey && stopped) stalls++;
		line_o <= 1'b0;
		repeat (DIV) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			line_o <= b[i];
			repeat (DIV) @(posedge clk_i);
		end
		line_o <= 1'b1;
		repeat (DIV) @(posedge clk_i);
	endtask
	// ****************************************
	// receiver
	// ****************************************
	// mid-bit sampling, frame kept only with a high stop bit
	always begin
		@(negedge line_i);
		repeat (DIV / 2) @(posedge clk_i);
		for (int k = 0; k < 8; k++) begin
			repeat (DIV) @(posedge clk_i);
			sh[k] = line_i;
		end
		repeat (DIV) @(posedge clk_i);
		if (line_i) begin
			got.push_back(sh);
			// flow state follows the device's XON and XOFF
			if (sh == 8'h13) begin
				stopped = 1'b1;
				xoffs++;
			end
			if (sh == 8'h11) stopped = 1'b0;
		end
	end
endmodule

// file: tb/tb.sv
// self-checking bench for the serial command line front end
`timescale 1ns/1ns
module tb;
	import scl_pkg::*;
	// ****************************************
	// signals and instances
	// ****************************************
	logic ref_clk_i = 1'b0; // clock
	logic rst_n_i; // reset
	logic ready_i; // device ready
	logic flow_en_i; // flow control on
	logic echo_en_i; // echo mode
	logic prompt_en_i; // prompt mode
	logic cmd_ready_i; // parser takes
	logic parse_done_i; // line dispatched
	logic [7:0] resp_data_i; // response byte
	logic resp_valid_i; // response valid
	logic go_local_i; // leave remote
	logic rxd_i, txd_o, dsr_o, cmd_valid_o, resp_ready_o, remote_o, query_err_o;
	cmd_word_s cmd_o;
	logic [8:0] words[$]; // words taken by the parser
	int fails = 0;
	int tests_run = 0;
	int qerrs = 0;
	int n = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	serial_command_line #(.BAUD_DIV(16'h0010), .XON_CYCLES(32'h000007D0)) serial_command_line_i (
		.ref_clk_i, .rst_n_i, .rxd_i, .txd_o, .dsr_o, .ready_i, .flow_en_i, .echo_en_i, .prompt_en_i,
		.cmd_o, .cmd_valid_o, .cmd_ready_i, .parse_done_i, .resp_data_i, .resp_valid_i,
		.resp_ready_o, .remote_o, .go_local_i, .query_err_o);
	host_term #(.DIV(16)) host_term_i (.clk_i(ref_clk_i), .line_i(txd_o), .line_o(rxd_i));
	// parser side and error pulse monitor
	always @(posedge ref_clk_i) begin
		if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) words.push_back(cmd_o);
		if (query_err_o === 1'b1) qerrs++;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// next byte from the device; periodic XON skipped unless awaited
	task automatic tx(input logic [7:0] b);
		logic [8:0] v = 9'h1FF;
		for (int w = 0; w < 9000 && v[8]; w++) begin
			@(posedge ref_clk_i);
			if (host_term_i.got.size() > 0) v = {1'b0, host_term_i.got.pop_front()};
			if (v == 9'h011 && b != 8'h11) v = 9'h1FF;
		end
		check("tx", v, {1'b0, b});
		if (v[8]) results();
	endtask
	task automatic txs(input string s);
		foreach (s[i]) tx(s[i]);
	endtask
	task automatic word(input logic [8:0] e);
		logic [8:0] v = 9'h1FF;
		for (int w = 0; w < 3000 && words.size() == 0; w++) @(posedge ref_clk_i);
		if (words.size() > 0) v = words.pop_front();
		check("cmd", v, e);
		if (v == 9'h1FF) results();
	endtask
	task automatic line(input string s);
		foreach (s[i]) host_term_i.put(s[i]);
	endtask
	task automatic done();
		parse_done_i <= 1'b1;
		@(posedge ref_clk_i);
		parse_done_i <= 1'b0;
	endtask
	// request held until the edge that samples ready high
	task automatic resp(input logic [7:0] b);
		logic ok = 1'b0;
		resp_data_i <= b;
		resp_valid_i <= 1'b1;
		for (int w = 0; w < 200 && !ok; w++) begin
			@(posedge ref_clk_i);
			ok = resp_ready_o === 1'b1;
		end
		check("resp", 9'(ok), 9'h001);
		if (!ok) results();
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		rst_n_i <= 1'b0;
		ready_i <= 1'b1;
		flow_en_i <= 1'b1;
		echo_en_i <= 1'b0;
		prompt_en_i <= 1'b0;
		cmd_ready_i <= 1'b1;
		parse_done_i <= 1'b0;
		resp_data_i <= 8'h00;
		resp_valid_i <= 1'b0;
		go_local_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		check("dsr", 9'(dsr_o), 9'h000);
		check("txd", 9'(txd_o), 9'h001);
		rst_n_i <= 1'b1;
		tx(8'h11);
		check("dsr", 9'(dsr_o), 9'h001);
		ready_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		check("dsr", 9'(dsr_o), 9'h000);
		ready_i <= 1'b1;
		// echo with backspace, stray control code and a CR LF pair
		cmd_ready_i <= 1'b0;
		echo_en_i <= 1'b1;
		line("A\001X\010B\015\012");
		txs("AX\010 \010B\023\015");
		check("dsr", 9'(dsr_o), 9'h000);
		check("remote", 9'(remote_o), 9'h001);
		// parser held off: the line waits in the queue with valid standing
		check("cmd_wait", 9'({cmd_valid_o, words.size() == 0}), 9'h003);
		cmd_ready_i <= 1'b1;
		word(9'h041);
		word(9'h042);
		word(9'h10D);
		done();
		txs("\015\012");
		tx(8'h11);
		check("dsr", 9'(dsr_o), 9'h001);
		go_local_i <= 1'b1;
		@(posedge ref_clk_i);
		go_local_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		check("remote", 9'(remote_o), 9'h000);
		// escape mid-line, then a line answered with a prompt
		echo_en_i <= 1'b0;
		line("QZ\033");
		txs("\015\012");
		line("C\015");
		tx(8'h13);
		word(9'h043);
		word(9'h10D);
		prompt_en_i <= 1'b1;
		done();
		txs("\015\012>");
		prompt_en_i <= 1'b0;
		// second line queued behind the first
		host_term_i.obey = 1'b0;
		line("D\015E\015");
		word(9'h044);
		word(9'h10D);
		repeat (40) @(posedge ref_clk_i);
		check("held", 9'(words.size()), 9'h000);
		done();
		word(9'h045);
		word(9'h10D);
		done();
		txs("\023\023\015\012\015\012");
		host_term_i.obey = 1'b1;
		// halt by XOFF, resume by XON
		host_term_i.put(8'h13);
		resp(8'h52);
		resp(8'h53);
		resp_valid_i <= 1'b0;
		repeat (200) @(posedge ref_clk_i);
		host_term_i.got.delete();
		repeat (400) @(posedge ref_clk_i);
		check("halted", 9'(host_term_i.got.size()), 9'h000);
		check("qerr", 9'(qerrs > 0), 9'h001);
		host_term_i.put(8'h11);
		txs("RS!");
		// cancel drops a partial line and queued output
		host_term_i.put(8'h13);
		line("AB");
		resp(8'h54);
		resp_valid_i <= 1'b0;
		host_term_i.put(8'h18);
		host_term_i.put(8'h11);
		tx(8'h21);
		line("F\015");
		tx(8'h13);
		word(9'h046);
		word(9'h10D);
		done();
		txs("\015\012");
		// lost echo while the transmitter is halted
		ready_i <= 1'b0;
		echo_en_i <= 1'b1;
		host_term_i.put(8'h13);
		n = qerrs;
		line("abcdefghijklmnopqr");
		check("nak_err", 9'(qerrs > n), 9'h001);
		check("resp_ready", 9'(resp_ready_o), 9'h000);
		host_term_i.put(8'h11);
		txs("abcdefghijklmnopq\025!");
		host_term_i.put(8'h1B);
		txs("\015\012");
		echo_en_i <= 1'b0;
		ready_i <= 1'b1;
		// flow control off
		flow_en_i <= 1'b0;
		host_term_i.put(8'h13);
		resp(8'h55);
		resp_valid_i <= 1'b0;
		tx(8'h55);
		line("G\015");
		word(9'h047);
		word(9'h10D);
		done();
		txs("\015\012");
		repeat (4500) @(posedge ref_clk_i);
		check("quiet", 9'(host_term_i.got.size()), 9'h000);
		flow_en_i <= 1'b1;
		tx(8'h11);
		host_term_i.got.delete();
		repeat (4500) @(posedge ref_clk_i);
		check("xons", 9'(host_term_i.got.size()), 9'h002);
		// overflow of the input buffer
		host_term_i.obey = 1'b0;
		n = host_term_i.xoffs;
		repeat (300) host_term_i.put(8'h4B);
		host_term_i.put(8'h0D);
		repeat (800) @(posedge ref_clk_i);
		check("dsr", 9'(dsr_o), 9'h000);
		check("xoff", 9'(host_term_i.xoffs - n), 9'h000);
		check("count", 9'(words.size()), 9'h100);
		check("last", words[255], 9'h10D);
		words.delete();
		done();
		txs("\015\012");
		tx(8'h11);
		check("dsr", 9'(dsr_o), 9'h001);
		check("stalls", 9'(host_term_i.stalls), 9'h000);
		results();
	end
	// hang guard
	initial begin
		repeat (95000) @(posedge ref_clk_i);
		check("timeout", 9'h000, 9'h001);
		results();
	end
endmodule
